// ### hdl/tmr_defs.vh
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TMR_ADDR_CTRL1   8'h00
`define TMR_ADDR_CTRL2   8'h04
`define TMR_ADDR_STATUS  8'h08
`define TMR_ADDR_CAP1_HI 8'h0C
`define TMR_ADDR_CAP1_LO 8'h10
`define TMR_ADDR_CAP2_HI 8'h14
`define TMR_ADDR_CAP2_LO 8'h18
`define TMR_ADDR_CMP1_HI 8'h1C
`define TMR_ADDR_CMP1_LO 8'h20
`define TMR_ADDR_CMP2_HI 8'h24
`define TMR_ADDR_CMP2_LO 8'h28
`define TMR_ADDR_COUNT   8'h2C
// ----------------------------------------
// Control one fields
// ----------------------------------------
`define TMR_C1_IRQ_EN    7
`define TMR_C1_CMP_IRQ_EN 6
`define TMR_C1_LEVEL_TWO 2
`define TMR_C1_EDGE_ONE  1
`define TMR_C1_LEVEL_ONE 0
// ----------------------------------------
// Control two fields
// ----------------------------------------
`define TMR_C2_PIN_EN    7
`define TMR_C2_ONE_PULSE 5
`define TMR_C2_PWM       4
`define TMR_C2_PRESC_HI  3
`define TMR_C2_PRESC_LO  2
`define TMR_C2_EDGE_TWO  1
// ----------------------------------------
// Status fields
// ----------------------------------------
`define TMR_SR_CAP_ONE   7
`define TMR_SR_CMP_ONE   6
`define TMR_SR_CAP_TWO   4
`define TMR_SR_CMP_TWO   3
// ----------------------------------------
// Reset values and reload
// ----------------------------------------
`define TMR_CTRL_RESET   8'h00
`define TMR_CMP_RESET    16'h8000
`define TMR_RELOAD       16'hFFFC
`define TMR_COUNT_RESET  16'hFFFC
`endif

// ### hdl/tmr_pulse_pwm.v
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"

// Summary of operation
// - Setting one-pulse select in control two, with PWM select clear, enters one-pulse operation.
// - One-pulse trigger edge: capture counter, reload FFFCh, drive pulse level, set flag.
// - Capture flag one raises the interrupt when capture interrupts are enabled.
// - Status read with a capture flag set arms its clearance.
// - A later access to the capture low byte completes flag clearance.
// - One-pulse: counter equal compare one drives after-pulse level on the output.
// - One-pulse never sets compare flag one; compare flag two still requests interrupt.
// - PWM select wins when both mode bits are set.
// - One-pulse: input one captures only as the trigger edge; input two still captures.
// - One-pulse: compare two flags elapsed time but drives no waveform.
// - Counter advances at clock divided by 2, 4 or 8 per prescale select.
// - PWM: compare one match drives level one on the output.
// - PWM: compare two match drives level two on the output.
// - PWM: compare values move to shadows only at the period end.
// - PWM: high-byte write blocks shadow transfer until the low byte is written.
// - PWM comparison stays active regardless of compare inhibit.
// - PWM: compare two match reloads the counter with FFFCh.
// - PWM never sets either compare flag.
// - PWM: compare two match sets capture flag one and may interrupt.
// - Edge select one: 0 falling edge, 1 rising edge.
module tmr_pulse_pwm
  (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Timer pins and interrupt
    input  wire        capture_input_pin_one,
    input  wire        capture_input_pin_two,
    input  wire        global_irq_mask,
    output reg         compare_output_pin_one,
    output wire        compare_output_enable_one,
    output wire        timer_irq
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  timer_control_one_reg;
  reg  [7:0]  timer_control_two_reg;
  reg  [15:0] count_reg;
  reg  [2:0]  presc_reg;
  reg  [15:0] compare_value_one_reg;
  reg  [15:0] compare_value_two_reg;
  reg  [15:0] shadow_one_reg;
  reg  [15:0] shadow_two_reg;
  reg         cmp_lock_one_reg;
  reg         cmp_lock_two_reg;
  reg  [15:0] capture_value_one_reg;
  reg  [15:0] capture_value_two_reg;
  reg         capture_flag_one_reg;
  reg         capture_flag_two_reg;
  reg         compare_flag_one_reg;
  reg         compare_flag_two_reg;
  reg  [3:0]  clr_arm_reg;
  reg         cap1_in_reg;
  reg         cap2_in_reg;
  reg         aw_done_reg;
  reg         w_done_reg;
  reg  [7:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg         wstrb0_reg;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire pwm_mode = timer_control_two_reg[`TMR_C2_PWM];
  wire opm_mode = timer_control_two_reg[`TMR_C2_ONE_PULSE] & ~pwm_mode;
  wire [1:0] prescale_select = timer_control_two_reg[`TMR_C2_PRESC_HI:`TMR_C2_PRESC_LO];
  wire lvl_one = timer_control_one_reg[`TMR_C1_LEVEL_ONE];
  wire lvl_two = timer_control_one_reg[`TMR_C1_LEVEL_TWO];

  // Prescale 00 -> /2, 01 -> /4, 10 and 11 -> /8
  reg [2:0] presc_last;
  always @*
  begin
    case (prescale_select)
      2'b00:   presc_last = 3'h1;
      2'b01:   presc_last = 3'h3;
      default: presc_last = 3'h7;
    endcase
  end
  wire tick = (presc_reg >= presc_last);

  // ----------------------------------------
  // Edge detect on the capture inputs
  // ----------------------------------------
  wire edge_one_rise = capture_input_pin_one & ~cap1_in_reg;
  wire edge_one_fall = ~capture_input_pin_one & cap1_in_reg;
  wire edge_one = timer_control_one_reg[`TMR_C1_EDGE_ONE] ? edge_one_rise : edge_one_fall;
  wire edge_two_rise = capture_input_pin_two & ~cap2_in_reg;
  wire edge_two_fall = ~capture_input_pin_two & cap2_in_reg;
  wire edge_two = timer_control_two_reg[`TMR_C2_EDGE_TWO] ? edge_two_rise : edge_two_fall;

  // ----------------------------------------
  // Compare matches
  // ----------------------------------------
  // PWM compares against shadows every tick; no inhibit applies
  wire [15:0] cmp1_val = pwm_mode ? shadow_one_reg : compare_value_one_reg;
  wire [15:0] cmp2_val = pwm_mode ? shadow_two_reg : compare_value_two_reg;
  wire match_one = tick & (count_reg == cmp1_val) & (pwm_mode | ~cmp_lock_one_reg);
  wire match_two = tick & (count_reg == cmp2_val) & (pwm_mode | ~cmp_lock_two_reg);
  wire opm_trig = opm_mode & edge_one;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire wr_fire = aw_done_reg & w_done_reg & ~s_axi_bvalid;
  wire rd_fire = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = ~aw_done_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_done_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire [7:0] wb = wdata_reg[7:0];
  wire wr_ok = wr_fire & wstrb0_reg;
  wire wr_c1   = wr_ok & (awaddr_reg == `TMR_ADDR_CTRL1);
  wire wr_c2   = wr_ok & (awaddr_reg == `TMR_ADDR_CTRL2);
  wire wr_o1h  = wr_ok & (awaddr_reg == `TMR_ADDR_CMP1_HI);
  wire wr_o1l  = wr_ok & (awaddr_reg == `TMR_ADDR_CMP1_LO);
  wire wr_o2h  = wr_ok & (awaddr_reg == `TMR_ADDR_CMP2_HI);
  wire wr_o2l  = wr_ok & (awaddr_reg == `TMR_ADDR_CMP2_LO);
  wire rd_sr   = rd_fire & (s_axi_araddr == `TMR_ADDR_STATUS);
  wire acc_c1l = (rd_fire & (s_axi_araddr == `TMR_ADDR_CAP1_LO))
               | (wr_fire & (awaddr_reg == `TMR_ADDR_CAP1_LO));
  wire acc_c2l = (rd_fire & (s_axi_araddr == `TMR_ADDR_CAP2_LO))
               | (wr_fire & (awaddr_reg == `TMR_ADDR_CAP2_LO));
  wire [7:0] status_byte = {capture_flag_one_reg, compare_flag_one_reg, 1'b0,
                            capture_flag_two_reg, compare_flag_two_reg, 3'b000};

  reg [31:0] rd_mux;
  reg        rd_hit;
  always @*
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `TMR_ADDR_CTRL1:   rd_mux[7:0] = timer_control_one_reg;
      `TMR_ADDR_CTRL2:   rd_mux[7:0] = timer_control_two_reg;
      `TMR_ADDR_STATUS:  rd_mux[7:0] = status_byte;
      `TMR_ADDR_CAP1_HI: rd_mux[7:0] = capture_value_one_reg[15:8];
      `TMR_ADDR_CAP1_LO: rd_mux[7:0] = capture_value_one_reg[7:0];
      `TMR_ADDR_CAP2_HI: rd_mux[7:0] = capture_value_two_reg[15:8];
      `TMR_ADDR_CAP2_LO: rd_mux[7:0] = capture_value_two_reg[7:0];
      `TMR_ADDR_CMP1_HI: rd_mux[7:0] = compare_value_one_reg[15:8];
      `TMR_ADDR_CMP1_LO: rd_mux[7:0] = compare_value_one_reg[7:0];
      `TMR_ADDR_CMP2_HI: rd_mux[7:0] = compare_value_two_reg[15:8];
      `TMR_ADDR_CMP2_LO: rd_mux[7:0] = compare_value_two_reg[7:0];
      `TMR_ADDR_COUNT:   rd_mux[15:0] = count_reg;
      default:           rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_done_reg  <= 1'b0;
      w_done_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_done_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_done_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_done_reg  <= 1'b0;
        w_done_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg <= `TMR_ADDR_COUNT) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Timer core
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_control_one_reg  <= `TMR_CTRL_RESET;
      timer_control_two_reg  <= `TMR_CTRL_RESET;
      count_reg              <= `TMR_COUNT_RESET;
      presc_reg              <= 3'h0;
      compare_value_one_reg  <= `TMR_CMP_RESET;
      compare_value_two_reg  <= `TMR_CMP_RESET;
      shadow_one_reg         <= `TMR_CMP_RESET;
      shadow_two_reg         <= `TMR_CMP_RESET;
      cmp_lock_one_reg       <= 1'b0;
      cmp_lock_two_reg       <= 1'b0;
      capture_value_one_reg  <= 16'h0000;
      capture_value_two_reg  <= 16'h0000;
      capture_flag_one_reg   <= 1'b0;
      capture_flag_two_reg   <= 1'b0;
      compare_flag_one_reg   <= 1'b0;
      compare_flag_two_reg   <= 1'b0;
      clr_arm_reg            <= 4'h0;
      cap1_in_reg            <= 1'b0;
      cap2_in_reg            <= 1'b0;
      compare_output_pin_one <= 1'b0;
    end
    else
    begin
      cap1_in_reg <= capture_input_pin_one;
      cap2_in_reg <= capture_input_pin_two;
      if (wr_c1)
        timer_control_one_reg <= wb;
      if (wr_c2)
        timer_control_two_reg <= {wb[7:6], wb[5:4], wb[3:1], 1'b0};
      // Compare writes: high byte locks until the low byte lands
      if (wr_o1h)
      begin
        compare_value_one_reg[15:8] <= wb;
        cmp_lock_one_reg            <= 1'b1;
      end
      if (wr_o1l)
      begin
        compare_value_one_reg[7:0] <= wb;
        cmp_lock_one_reg           <= 1'b0;
      end
      if (wr_o2h)
      begin
        compare_value_two_reg[15:8] <= wb;
        cmp_lock_two_reg            <= 1'b1;
      end
      if (wr_o2l)
      begin
        compare_value_two_reg[7:0] <= wb;
        cmp_lock_two_reg           <= 1'b0;
      end
      // Prescaler and counter
      presc_reg <= tick ? 3'h0 : presc_reg + 3'h1;
      if (opm_trig | (pwm_mode & match_two))
        count_reg <= `TMR_RELOAD;
      else if (tick)
        count_reg <= count_reg + 16'h0001;
      // In PWM, shadows update only at the period end, and never mid-write; otherwise they copy every cycle
      if (pwm_mode & match_two)
      begin
        if (!cmp_lock_one_reg)
          shadow_one_reg <= compare_value_one_reg;
        if (!cmp_lock_two_reg)
          shadow_two_reg <= compare_value_two_reg;
      end
      else if (!pwm_mode)
      begin
        shadow_one_reg <= compare_value_one_reg;
        shadow_two_reg <= compare_value_two_reg;
      end
      // Output waveform
      if (pwm_mode)
      begin
        if (match_two)
          compare_output_pin_one <= lvl_two;
        else if (match_one)
          compare_output_pin_one <= lvl_one;
      end
      else if (opm_mode)
      begin
        if (opm_trig)
          compare_output_pin_one <= lvl_two;
        else if (match_one)
          compare_output_pin_one <= lvl_one;
      end
      else if (match_one)
        compare_output_pin_one <= lvl_one;
      // Status read arms clearance of each set flag
      if (rd_sr)
        clr_arm_reg <= {capture_flag_one_reg, capture_flag_two_reg,
                        compare_flag_one_reg, compare_flag_two_reg};
      // Capture one: opm trigger or ordinary edge when idle; pwm period end sets the flag only
      if (opm_trig | (!opm_mode & !pwm_mode & edge_one))
        capture_value_one_reg <= count_reg;
      if (opm_trig | (pwm_mode & match_two) | (!opm_mode & !pwm_mode & edge_one))
        capture_flag_one_reg <= 1'b1;
      else if (acc_c1l & clr_arm_reg[3])
      begin
        capture_flag_one_reg <= 1'b0;
        clr_arm_reg[3]       <= 1'b0;
      end
      if (edge_two)
      begin
        capture_value_two_reg <= count_reg;
        capture_flag_two_reg  <= 1'b1;
      end
      else if (acc_c2l & clr_arm_reg[2])
      begin
        capture_flag_two_reg <= 1'b0;
        clr_arm_reg[2]       <= 1'b0;
      end
      // Compare flags
      if (match_one & !opm_mode & !pwm_mode)
        compare_flag_one_reg <= 1'b1;
      else if (wr_o1l & clr_arm_reg[1])
      begin
        compare_flag_one_reg <= 1'b0;
        clr_arm_reg[1]       <= 1'b0;
      end
      if (match_two & !pwm_mode)
        compare_flag_two_reg <= 1'b1;
      else if (wr_o2l & clr_arm_reg[0])
      begin
        compare_flag_two_reg <= 1'b0;
        clr_arm_reg[0]       <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin enable and interrupt
  // ----------------------------------------
  assign compare_output_enable_one = timer_control_two_reg[`TMR_C2_PIN_EN];
  assign timer_irq = ~global_irq_mask &
    ((timer_control_one_reg[`TMR_C1_IRQ_EN] & (capture_flag_one_reg | capture_flag_two_reg))
     | (timer_control_one_reg[`TMR_C1_CMP_IRQ_EN] & (compare_flag_one_reg | compare_flag_two_reg)));

endmodule
`default_nettype wire

// ### testbench/tmr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_monitor
  (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Interrupt
    input wire logic        global_irq_mask,
    input wire logic        timer_irq
  );
  // Any bus access that may clear a flag
  wire bus_act = s_axi_arvalid | s_axi_wvalid;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------
  // Handshake steps
  // ------
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_both |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pends");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pends");
  bad_addr_a: assert property (rd_take and s_axi_araddr > 8'h2C |=> s_axi_rresp == 2'b10 && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  irq_mask_a: assert property (global_irq_mask |-> !timer_irq)
    else $error("interrupt leaks through mask");
  // Flags only clear by software, so the request drops only after an access
  irq_clear_a: assert property ($fell(timer_irq) && !global_irq_mask |-> $past(bus_act) || $past(bus_act, 2))
    else $error("interrupt dropped without access");
endmodule
bind tmr_pulse_pwm tmr_monitor u_mon (.*);
`default_nettype wire

// ### testbench/tmr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model
  (
    // Clock
    input  wire logic        aclk,
    // Bench commands
    input  wire logic [1:0]  kick,
    input  wire logic [1:0]  rise,
    // Capture pins
    output wire logic [1:0]  cap_pin,
    // Compare pin load
    input  wire logic        out_pin,
    input  wire logic        out_en,
    output var  logic [15:0] width,
    output var  logic [7:0]  falls
  );
  logic [2:0]  hold [2];
  logic [15:0] run;
  initial
  begin
    hold = '{3'h0, 3'h0};
    run = '0;
    width = '0;
    falls = '0;
  end
  // Idle at the opposite level, so a kick gives exactly the chosen edge
  assign cap_pin = ~rise ^ {hold[1] != 3'h0, hold[0] != 3'h0};
  always @(posedge aclk)
  begin
    for (int i = 0; i < 2; i++)
      hold[i] <= kick[i] ? 3'h4 : hold[i] - (hold[i] != 3'h0);
    // Load sees the waveform only while the pin is dedicated
    if (out_en && out_pin)
      run <= run + 16'h1;
    else if (run != 16'h0)
    begin
      width <= run;
      falls <= falls + 8'h1;
      run <= '0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/timer_one_pulse_and_pwm_modes_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"
module timer_one_pulse_and_pwm_modes_tb;
  logic        aclk = 0, aresetn = 0, global_irq_mask = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, rv;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0]  kick = '0, rise = '0, rr, br;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         capture_input_pin_one, capture_input_pin_two, timer_irq;
  wire         compare_output_pin_one, compare_output_enable_one;
  wire  [15:0] width;
  wire  [7:0]  falls;
  int          error_cnt = 0, comparisons = 0, p;
  tmr_pulse_pwm u_dut (.*);
  tmr_pin_model u_pins (.aclk(aclk), .kick(kick), .rise(rise),
    .cap_pin({capture_input_pin_two, capture_input_pin_one}), .out_pin(compare_output_pin_one),
    .out_en(compare_output_enable_one), .width(width), .falls(falls));
  initial forever #50 aclk = ~aclk;
  // ------
  // Bus and compare tasks
  // ------
  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    begin
      k = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
        @(posedge aclk);
        k++;
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1 && k < 50);
      br = s_axi_bresp;
      chk("write done", 32'h1, s_axi_bvalid);
      s_axi_bready <= 0;
    end
  endtask
  task rd(input logic [7:0] a);
    int k;
    begin
      k = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
        @(posedge aclk);
        k++;
        if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1 && k < 50);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      chk("read done", 32'h1, s_axi_rvalid);
      s_axi_rready <= 0;
    end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_rng(input string n, input int lo, input int hi, input logic [15:0] g);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      error_cnt++;
      $display("BAD %s expected %0d to %0d seen %0d", n, lo, hi, g);
    end
  endtask
  // Bounded: a dead output must not hang the run
  task wait_falls(input int n);
    int k;
    logic [7:0] f;
    begin
      f = falls;
      k = 0;
      while (falls !== 8'(f + n) && k < 3000)
      begin
        @(posedge aclk);
        k++;
      end
      chk("load falls", 8'(f + n), falls);
    end
  endtask
  task kick_pin(input logic [1:0] m);
    @(posedge aclk);
    kick <= m;
    @(posedge aclk);
    kick <= '0;
  endtask
  task close_out;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    close_out;
  end
  // ------
  // Scenarios
  // ------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(`TMR_ADDR_STATUS);
    chk("status reset", 8'h00, rv);
    rd(`TMR_ADDR_CMP2_HI);
    chk("compare two reset", 8'h80, rv);
    rd(8'h30);
    chk("unmapped resp", 2'b10, rr);
    wr(`TMR_ADDR_CMP1_HI, 8'h00);
    chk("write resp", 2'b00, br);
    wr(`TMR_ADDR_CMP1_LO, 8'h0A);
    for (int i = 0; i < 3; i++)
    begin
      p = 2 << i;
      wr(`TMR_ADDR_CTRL2, 8'h00);
      rise <= {1'b0, i != 1};
      wr(`TMR_ADDR_CTRL1, 8'h84 | ((i != 1) << 1));
      wr(`TMR_ADDR_CTRL2, 8'hA0 | (i << 2));
      kick_pin(2'b01);
      wait_falls(1);
      chk_rng("pulse width", 13 * p, 15 * p + 3, width);
      rd(`TMR_ADDR_STATUS);
      chk("pulse flags", 8'h80, rv & 8'hC0);
      chk("pulse irq", 1, timer_irq);
      global_irq_mask <= 1;
      @(posedge aclk);
      chk("masked irq", 0, timer_irq);
      global_irq_mask <= 0;
      rd(`TMR_ADDR_CAP1_LO);
      rd(`TMR_ADDR_STATUS);
      chk("flag cleared", 8'h00, rv & 8'h80);
    end
    kick_pin(2'b10);
    repeat (3) @(posedge aclk);
    rd(`TMR_ADDR_STATUS);
    chk("capture two flag", 8'h10, rv & 8'h10);
    rd(`TMR_ADDR_CAP2_LO);
    // A last trigger reloads the counter, so the first PWM period starts below compare two
    wr(`TMR_ADDR_CTRL1, 8'h81);
    kick_pin(2'b01);
    repeat (6) @(posedge aclk);
    rd(`TMR_ADDR_STATUS);
    rd(`TMR_ADDR_CAP1_LO);
    rd(`TMR_ADDR_STATUS);
    chk("flags before pwm", 8'h00, rv & 8'h90);
    wr(`TMR_ADDR_CMP2_HI, 8'h00);
    wr(`TMR_ADDR_CMP2_LO, 8'h14);
    wr(`TMR_ADDR_CMP1_LO, 8'h08);
    wr(`TMR_ADDR_CTRL2, 8'hB0);
    wait_falls(2);
    chk_rng("pwm high", 21, 27, width);
    rd(`TMR_ADDR_STATUS);
    chk("pwm flags", 8'h80, rv & 8'hC8);
    chk("pwm irq", 1, timer_irq);
    // A pending high byte alone would kill the pulse if it reached the shadow
    wr(`TMR_ADDR_CMP1_HI, 8'h01);
    wait_falls(2);
    chk_rng("locked high", 21, 27, width);
    wr(`TMR_ADDR_CMP1_HI, 8'h00);
    wr(`TMR_ADDR_CMP1_LO, 8'h04);
    wait_falls(2);
    chk_rng("buffered high", 29, 35, width);
    wr(8'h30, 32'h0000_0000);
    chk("unmapped write", 2'b10, br);
    close_out;
  end
endmodule
`default_nettype wire
